// [pmx_pkg.sv]
// constants, carrier structs and decoding helpers for the pad mux and pin event logic
package pmx_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int          PMX_NUM_PADS     = 32;
  localparam int          PMX_PULL_PADS    = 16;
  localparam int          PMX_SHARE_NUM    = 4;
  localparam int          PMX_SHARE_I2C    = 4;

  // ----------------------------------------------------------------
  // pad indices, port a bits 0..7, b 8..15, c 16..23, d 24..31
  // ----------------------------------------------------------------
  localparam logic [4:0]  PMX_PAD_PA2      = 5'h02;
  localparam logic [4:0]  PMX_PAD_PA3      = 5'h03;
  localparam logic [4:0]  PMX_PAD_PA4      = 5'h04;
  localparam logic [4:0]  PMX_PAD_PB6      = 5'h0e;
  localparam logic [4:0]  PMX_PAD_PD2      = 5'h1a;
  localparam logic [4:0]  PMX_PAD_PD7      = 5'h1f;

  // ----------------------------------------------------------------
  // function field codes and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0]  PMX_FUNC_SPI_DO  = 2'h0;
  localparam logic [1:0]  PMX_FUNC_CS      = 2'h0;
  localparam logic [1:0]  PMX_FUNC_PULSE   = 2'h2;
  localparam logic [31:0] PMX_STRONG_RESET = 32'hffffffff;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] input_gate;
    logic [31:0] output_drive_disable;
    logic [31:0] out_value;
    logic [31:0] polarity;
    logic [31:0] drive_strength_select;
    logic [31:0] general_purpose_select;
    logic [31:0] irq_pin_mask;
    logic [31:0] timer0_pin_mask;
    logic [31:0] timer1_pin_mask;
    logic [31:0] timer2_pin_mask;
    logic [1:0]  pa2_function;
    logic [1:0]  pd2_function;
    logic [3:0]  share_out_select;
    logic [7:0]  share_in_select;
    logic        irq_block_enable;
  } pmx_cfg_t;

  typedef struct packed {
    logic        serial_data_out;
    logic        serial_data_out_disable;
    logic        serial_chip_select_function;
    logic        serial_chip_select_disable;
    logic        pulse_output_zero;
    logic        pulse_output_three;
    logic        share_data_out;
    logic        share_data_disable;
    logic        share_clock_out;
    logic        share_clock_disable;
  } pmx_periph_t;

  typedef struct packed {
    logic        serial_data_in_function;
    logic        serial_clock_function;
    logic        i2c_data_in;
    logic        i2c_clock_in;
  } pmx_share_in_t;

  typedef struct packed {
    logic [31:0] irq_status;
    logic [31:0] timer0_status;
    logic [31:0] timer1_status;
    logic [31:0] timer2_status;
    logic        gpio_irq_req;
    logic        gpio_irq_cpu;
    logic [2:0]  timer_signal;
    logic [1:0]  pin_to_cpu_interrupt;
  } pmx_event_t;

  // ----------------------------------------------------------------
  // shared serial pad k: even k carries data, odd k carries clock
  // ----------------------------------------------------------------
  function automatic logic [4:0] pmx_share_pad(input int k);
    logic [4:0] pad;
    pad = PMX_PAD_PA3;
    unique case (k)
      1: pad = PMX_PAD_PA4;
      2: pad = PMX_PAD_PB6;
      3: pad = PMX_PAD_PD7;
      default: pad = PMX_PAD_PA3;
    endcase
    return pad;
  endfunction : pmx_share_pad

endpackage : pmx_pkg

// [pmx_event_reduce.sv]
// masked polarity-adjusted pin reduction for one event target
`timescale 1ns/10ps
`default_nettype none
module pmx_event_reduce (
  input  wire logic [31:0] adjusted,
  input  wire logic [31:0] mask,
  output logic      [31:0] hits,
  output logic             any
);

  // ----------------------------------------------------------------
  // per pin hits and or reduction
  // ----------------------------------------------------------------
  assign hits = adjusted & mask;
  assign any  = |hits;

endmodule : pmx_event_reduce
`default_nettype wire

// [pmx_pad_select.sv]
// per pad choice between general purpose drive and peripheral functions
`timescale 1ns/10ps
`default_nettype none
module pmx_pad_select (
  input  wire logic                 pd2_gp_seen,
  input  wire pmx_pkg::pmx_cfg_t    cfg,
  input  wire pmx_pkg::pmx_periph_t periph,
  output logic [31:0]               drv_out,
  output logic [31:0]               drv_oe
);

  logic [31:0] gp_mode;
  logic [4:0]  pad;

  // ----------------------------------------------------------------
  // output routing
  // ----------------------------------------------------------------
  always_comb begin
    pad = 5'h00;
    gp_mode = cfg.general_purpose_select;
    gp_mode[pmx_pkg::PMX_PAD_PD2] = cfg.general_purpose_select[pmx_pkg::PMX_PAD_PD2] & pd2_gp_seen;
    drv_out = cfg.out_value & gp_mode;
    drv_oe = ~cfg.output_drive_disable & gp_mode;
    if (!gp_mode[pmx_pkg::PMX_PAD_PA2]) begin
      unique case (cfg.pa2_function)
        pmx_pkg::PMX_FUNC_SPI_DO: begin
          drv_out[pmx_pkg::PMX_PAD_PA2] = periph.serial_data_out;
          drv_oe[pmx_pkg::PMX_PAD_PA2] = ~periph.serial_data_out_disable;
        end
        pmx_pkg::PMX_FUNC_PULSE: begin
          drv_out[pmx_pkg::PMX_PAD_PA2] = periph.pulse_output_zero;
          drv_oe[pmx_pkg::PMX_PAD_PA2] = 1'b1;
        end
        default: begin
          drv_out[pmx_pkg::PMX_PAD_PA2] = 1'b0;
          drv_oe[pmx_pkg::PMX_PAD_PA2] = 1'b0;
        end
      endcase
    end
    if (!gp_mode[pmx_pkg::PMX_PAD_PD2]) begin
      unique case (cfg.pd2_function)
        pmx_pkg::PMX_FUNC_CS: begin
          drv_out[pmx_pkg::PMX_PAD_PD2] = periph.serial_chip_select_function;
          drv_oe[pmx_pkg::PMX_PAD_PD2] = ~periph.serial_chip_select_disable;
        end
        pmx_pkg::PMX_FUNC_PULSE: begin
          drv_out[pmx_pkg::PMX_PAD_PD2] = periph.pulse_output_three;
          drv_oe[pmx_pkg::PMX_PAD_PD2] = 1'b1;
        end
        default: begin
          drv_out[pmx_pkg::PMX_PAD_PD2] = 1'b0;
          drv_oe[pmx_pkg::PMX_PAD_PD2] = 1'b0;
        end
      endcase
    end
    for (int k = 0; k < pmx_pkg::PMX_SHARE_NUM; k++) begin
      pad = pmx_pkg::pmx_share_pad(k);
      if (!gp_mode[pad] && cfg.share_out_select[k]) begin
        if (k % 2 == 0) begin
          drv_out[pad] = periph.share_data_out;
          drv_oe[pad] = ~periph.share_data_disable;
        end else begin
          drv_out[pad] = periph.share_clock_out;
          drv_oe[pad] = ~periph.share_clock_disable;
        end
      end
    end
  end

endmodule : pmx_pad_select
`default_nettype wire

// [pmx_pad_mux.sv]
// pad mux and pin event logic top
// Functional notes
// - with gate and disable set, the sampled pad level is readable.
// - pa2 in function mode routes serial data out on 00, pulse zero on 10.
// - pd2 starts as chip select; general mode only after its select bit is set.
// - pd2 in function mode routes pulse three on 10.
// - four bit field picks per shared pad whether the shared serial output drives it.
// - eight bit field picks per shared pad whether it feeds spi input, i2c input, both or neither.
// - pa3 and pa4 have independent spi, i2c input and output select bits.
// - drive strength one is maximum, zero minimum; default maximum; only while driving.
// - output disable high leaves pad undriven; low drives the stored value.
// - input gate low forces the internal input value to zero.
// - in serial function modes the peripheral's own output disable controls the driver; pulse modes always drive.
// - pads outside groups c and d pull up when disable and input are both one.
// - gpio request is or over pads of input xor polarity and mask.
// - each timer signal is or of adjusted input and that timer's pin mask.
// - two cpu interrupt lines reuse the timer0 and timer1 masks.
// - polarity inverts the pad input to choose the triggering edge.
// - request reaches the cpu only with masks and block enable set.
// - irq status shows which pads assert the gpio request, bit n is pin n.
// - polarity selects the counting or starting edge for timers.
// - per timer status shows which pads assert its signal.
`timescale 1ns/10ps
`default_nettype none
module pmx_pad_mux (
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire pmx_pkg::pmx_cfg_t     cfg,
  input  wire pmx_pkg::pmx_periph_t  periph,
  input  wire logic [31:0]           pad_in,
  output logic [31:0]                pad_out,
  output logic [31:0]                pad_oe,
  output logic [31:0]                pad_drive_strong,
  output logic [31:0]                pad_pullup,
  output logic [31:0]                in_value,
  output pmx_pkg::pmx_share_in_t     shared_in,
  output pmx_pkg::pmx_event_t        events
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0]            in_gated;
    logic [31:0]            pad_out;
    logic [31:0]            pad_oe;
    logic [31:0]            pad_strong;
    logic [31:0]            pad_pullup;
    pmx_pkg::pmx_share_in_t share;
    pmx_pkg::pmx_event_t    ev;
    logic                   pd2_gp_seen;
  } pmx_state_t;

  pmx_state_t  state;
  pmx_state_t  next_state;
  logic [31:0] adjusted;
  logic [31:0] drv_out;
  logic [31:0] drv_oe;
  logic [31:0] irq_hits;
  logic [31:0] t0_hits;
  logic [31:0] t1_hits;
  logic [31:0] t2_hits;
  logic        irq_any;
  logic        t0_any;
  logic        t1_any;
  logic        t2_any;
  logic [4:0]  pad;

  // ----------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------
  assign adjusted = state.in_gated ^ cfg.polarity;

  pmx_pad_select u_select (
    .pd2_gp_seen (state.pd2_gp_seen),
    .cfg         (cfg),
    .periph      (periph),
    .drv_out     (drv_out),
    .drv_oe      (drv_oe)
  );

  pmx_event_reduce u_irq (
    .adjusted (adjusted),
    .mask     (cfg.irq_pin_mask),
    .hits     (irq_hits),
    .any      (irq_any)
  );

  pmx_event_reduce u_t0 (
    .adjusted (adjusted),
    .mask     (cfg.timer0_pin_mask),
    .hits     (t0_hits),
    .any      (t0_any)
  );

  pmx_event_reduce u_t1 (
    .adjusted (adjusted),
    .mask     (cfg.timer1_pin_mask),
    .hits     (t1_hits),
    .any      (t1_any)
  );

  pmx_event_reduce u_t2 (
    .adjusted (adjusted),
    .mask     (cfg.timer2_pin_mask),
    .hits     (t2_hits),
    .any      (t2_any)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    pad = 5'h00;
    next_state = state;
    next_state.in_gated = pad_in & cfg.input_gate;
    next_state.pad_out = drv_out;
    next_state.pad_oe = drv_oe;
    next_state.pad_strong = cfg.drive_strength_select | ~drv_oe;
    next_state.pad_pullup = 32'h00000000;
    for (int i = 0; i < pmx_pkg::PMX_PULL_PADS; i++) begin
      next_state.pad_pullup[i] = cfg.output_drive_disable[i] & state.in_gated[i];
    end
    next_state.share = '0;
    for (int k = 0; k < pmx_pkg::PMX_SHARE_NUM; k++) begin
      pad = pmx_pkg::pmx_share_pad(k);
      if (k % 2 == 0) begin
        next_state.share.serial_data_in_function |= cfg.share_in_select[k] & state.in_gated[pad];
        next_state.share.i2c_data_in |= cfg.share_in_select[k + pmx_pkg::PMX_SHARE_I2C] & state.in_gated[pad];
      end else begin
        next_state.share.serial_clock_function |= cfg.share_in_select[k] & state.in_gated[pad];
        next_state.share.i2c_clock_in |= cfg.share_in_select[k + pmx_pkg::PMX_SHARE_I2C] & state.in_gated[pad];
      end
    end
    next_state.ev.irq_status = irq_hits;
    next_state.ev.timer0_status = t0_hits;
    next_state.ev.timer1_status = t1_hits;
    next_state.ev.timer2_status = t2_hits;
    next_state.ev.gpio_irq_req = irq_any;
    next_state.ev.gpio_irq_cpu = irq_any & cfg.irq_block_enable;
    next_state.ev.timer_signal = {t2_any, t1_any, t0_any};
    next_state.ev.pin_to_cpu_interrupt = {t1_any, t0_any};
    if (cfg.general_purpose_select[pmx_pkg::PMX_PAD_PD2]) begin
      next_state.pd2_gp_seen = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= '0;
      state.pad_strong <= pmx_pkg::PMX_STRONG_RESET;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign pad_out          = state.pad_out;
  assign pad_oe           = state.pad_oe;
  assign pad_drive_strong = state.pad_strong;
  assign pad_pullup       = state.pad_pullup;
  assign in_value         = state.in_gated;
  assign shared_in        = state.share;
  assign events           = state.ev;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_pd2_function_cs;
    !state.pd2_gp_seen && cfg.pd2_function == pmx_pkg::PMX_FUNC_CS;
  endsequence

  sequence s_pd2_armed;
    cfg.general_purpose_select[pmx_pkg::PMX_PAD_PD2] ##1 cfg.general_purpose_select[pmx_pkg::PMX_PAD_PD2];
  endsequence

  a_input_gate_zero: assert property (
    1'b1 |=> (in_value & ~$past(cfg.input_gate)) == 32'h00000000)
    else $error("gated input leaked through");

  a_input_sample: assert property (
    cfg.input_gate[0] |=> in_value[0] == $past(pad_in[0]))
    else $error("input not sampled");

  a_gp_drive: assert property (
    cfg.general_purpose_select[0] |=> pad_oe[0] == !$past(cfg.output_drive_disable[0])
      && (pad_out[0] == $past(cfg.out_value[0])))
    else $error("general output wrong");

  a_pa2_data_out: assert property (
    !cfg.general_purpose_select[pmx_pkg::PMX_PAD_PA2] && cfg.pa2_function == pmx_pkg::PMX_FUNC_SPI_DO
      |=> pad_out[pmx_pkg::PMX_PAD_PA2] == $past(periph.serial_data_out)
      && pad_oe[pmx_pkg::PMX_PAD_PA2] == !$past(periph.serial_data_out_disable))
    else $error("pa2 data out not routed");

  a_pa2_pulse: assert property (
    !cfg.general_purpose_select[pmx_pkg::PMX_PAD_PA2] && cfg.pa2_function == pmx_pkg::PMX_FUNC_PULSE
      |=> pad_out[pmx_pkg::PMX_PAD_PA2] == $past(periph.pulse_output_zero) && pad_oe[pmx_pkg::PMX_PAD_PA2])
    else $error("pa2 pulse not routed");

  a_pd2_reset_cs: assert property (
    s_pd2_function_cs |=> pad_out[pmx_pkg::PMX_PAD_PD2] == $past(periph.serial_chip_select_function)
      && pad_oe[pmx_pkg::PMX_PAD_PD2] == !$past(periph.serial_chip_select_disable))
    else $error("pd2 chip select not routed");

  a_pd2_gp_arm: assert property (
    s_pd2_armed |=> pad_oe[pmx_pkg::PMX_PAD_PD2] == !$past(cfg.output_drive_disable[pmx_pkg::PMX_PAD_PD2]))
    else $error("pd2 general mode not taken");

  a_pd2_pulse: assert property (
    (!state.pd2_gp_seen || !cfg.general_purpose_select[pmx_pkg::PMX_PAD_PD2])
      && cfg.pd2_function == pmx_pkg::PMX_FUNC_PULSE
      |=> pad_out[pmx_pkg::PMX_PAD_PD2] == $past(periph.pulse_output_three))
    else $error("pd2 pulse not routed");

  a_share_out: assert property (
    !cfg.general_purpose_select[pmx_pkg::PMX_PAD_PA4] && cfg.share_out_select[1]
      |=> pad_out[pmx_pkg::PMX_PAD_PA4] == $past(periph.share_clock_out)
      && pad_oe[pmx_pkg::PMX_PAD_PA4] == !$past(periph.share_clock_disable))
    else $error("shared clock not routed");

  a_share_in_sel: assert property (
    cfg.share_in_select == 8'h10 |=> shared_in.i2c_data_in == $past(in_value[pmx_pkg::PMX_PAD_PA3])
      && !shared_in.serial_data_in_function)
    else $error("shared input select wrong");

  a_drive_strength: assert property (
    1'b1 |=> pad_drive_strong == ($past(cfg.drive_strength_select) | ~pad_oe))
    else $error("drive strength wrong");

  a_pullup_weak: assert property (
    1'b1 |=> pad_pullup[0] == ($past(cfg.output_drive_disable[0]) && $past(in_value[0]))
      && pad_pullup[pmx_pkg::PMX_PAD_PD2] == 1'b0)
    else $error("weak pull up wrong");

  a_irq_request: assert property (
    1'b1 |=> events.gpio_irq_req == |(($past(in_value) ^ $past(cfg.polarity)) & $past(cfg.irq_pin_mask)))
    else $error("gpio request wrong");

  a_irq_status: assert property (
    events.gpio_irq_req |-> events.irq_status != 32'h00000000)
    else $error("irq status empty while request set");

  a_irq_cpu_gate: assert property (
    1'b1 |=> events.gpio_irq_cpu == ($past(cfg.irq_block_enable) && events.gpio_irq_req))
    else $error("block enable not honoured");

  a_timer_cpu: assert property (
    events.pin_to_cpu_interrupt == events.timer_signal[1:0])
    else $error("cpu lines differ from timer masks");

  a_timer_status: assert property (
    1'b1 |=> events.timer2_status == (($past(in_value) ^ $past(cfg.polarity)) & $past(cfg.timer2_pin_mask))
      && events.timer_signal[2] == |events.timer2_status)
    else $error("timer2 signal wrong");

endmodule : pmx_pad_mux
`default_nettype wire

// [pmx_pad_partner.sv]
// external circuitry model standing at the package pads
`timescale 1ns/10ps
`default_nettype none
module pmx_pad_partner (
  input  wire logic        clk,
  input  wire logic [31:0] pad_out,
  input  wire logic [31:0] pad_oe,
  input  wire logic [31:0] pad_pullup,
  input  wire logic [31:0] ext_level,
  input  wire logic [31:0] ext_drive,
  output logic      [31:0] pad_in
);
  logic flip = 1'h0;
  always_ff @(posedge clk) begin
    flip <= ~flip;
  end
  // a released pad floats to a changing level unless something holds it
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      if (pad_oe[i])
        pad_in[i] = pad_out[i];
      else if (ext_drive[i])
        pad_in[i] = ext_level[i];
      else if (pad_pullup[i])
        pad_in[i] = 1'h1;
      else
        pad_in[i] = flip;
    end
  end
endmodule : pmx_pad_partner
`default_nettype wire

// [test_pad_mux_and_pin_event_logic.sv]
// self-checking bench for the pad mux and pin event logic
`timescale 1ns/10ps
`default_nettype none
module test_pad_mux_and_pin_event_logic;
  logic                  clk = 1'h0;
  logic                  reset = 1'h1;
  pmx_pkg::pmx_cfg_t     cfg, c;
  pmx_pkg::pmx_periph_t  periph, p;
  logic [31:0]           ext_level, ext_drive, lvl, drv;
  logic [31:0]           pad_in, pad_out, pad_oe, pad_drive_strong, pad_pullup, in_value;
  pmx_pkg::pmx_share_in_t shared_in;
  pmx_pkg::pmx_event_t   events;
  int                    bad_count = 0;
  int                    comparisons = 0;

  pmx_pad_mux dut_u (.clk(clk), .reset(reset), .cfg(cfg), .periph(periph), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .pad_drive_strong(pad_drive_strong),
    .pad_pullup(pad_pullup), .in_value(in_value), .shared_in(shared_in), .events(events));
  pmx_pad_partner pad_u (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup),
    .ext_level(ext_level), .ext_drive(ext_drive), .pad_in(pad_in));

  initial begin
    forever #10 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic fresh();
    c = '0;
    c.drive_strength_select = pmx_pkg::PMX_STRONG_RESET;
    p = '0;
    p.serial_data_out_disable = 1'h1;
    p.serial_chip_select_disable = 1'h1;
    p.share_data_disable = 1'h1;
    p.share_clock_disable = 1'h1;
    lvl = '0;
    drv = '0;
  endtask : fresh

  task automatic apply();
    @(posedge clk);
    cfg <= c;
    periph <= p;
    ext_level <= lvl;
    ext_drive <= drv;
    repeat (3) @(posedge clk);
    #1;
  endtask : apply

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_general_out();
    fresh();
    c.general_purpose_select[2] = 1'h1;
    c.out_value[2] = 1'h1;
    c.drive_strength_select[2] = 1'h0;
    apply();
    check("oe pa2", pad_oe, 32'h4);
    check("out pa2", pad_out[2], 1'h1);
    check("strength", pad_drive_strong, 32'hfffffffb);
    check("gated in", in_value, 32'h0);
    c.input_gate[2] = 1'h1;
    apply();
    check("looped in", in_value, 32'h4);
    c.output_drive_disable[2] = 1'h1;
    apply();
    check("oe off", pad_oe, 32'h0);
    check("strength idle", pad_drive_strong, 32'hffffffff);
  endtask : t_general_out

  task automatic t_general_in();
    fresh();
    c.general_purpose_select = 32'h00020020;
    c.output_drive_disable = 32'h00020020;
    c.input_gate = 32'h00020020;
    lvl = 32'h00020020;
    drv = 32'h00020020;
    apply();
    check("in value", in_value, 32'h00020020);
    check("pullup", pad_pullup, 32'h20);
    lvl = 32'h0;
    apply();
    check("in low", in_value, 32'h0);
    check("pullup low", pad_pullup, 32'h0);
  endtask : t_general_in

  task automatic t_functions();
    fresh();
    p.serial_data_out = 1'h1;
    p.serial_data_out_disable = 1'h0;
    p.serial_chip_select_function = 1'h1;
    p.serial_chip_select_disable = 1'h0;
    apply();
    check("pa2 data out", pad_oe & pad_out, 32'h04000004);
    p.serial_data_out_disable = 1'h1;
    p.pulse_output_zero = 1'h1;
    apply();
    check("pa2 periph off", pad_oe[2], 1'h0);
    c.pa2_function = pmx_pkg::PMX_FUNC_PULSE;
    apply();
    check("pa2 pulse", pad_oe[2] & pad_out[2], 1'h1);
    p.pulse_output_zero = 1'h0;
    apply();
    check("pa2 pulse low", pad_out[2], 1'h0);
    c.pa2_function = 2'h1;
    apply();
    check("pa2 undefined", pad_oe[2], 1'h0);
    c.pa2_function = 2'h0;
    c.pd2_function = pmx_pkg::PMX_FUNC_PULSE;
    p.pulse_output_three = 1'h1;
    apply();
    check("pd2 pulse", pad_oe[26] & pad_out[26], 1'h1);
    c.general_purpose_select[26] = 1'h1;
    apply();
    check("pd2 general", {pad_oe[26], pad_out[26]}, 2'h2);
  endtask : t_functions

  task automatic t_shared();
    fresh();
    c.share_out_select = 4'h1;
    c.input_gate = 32'h18;
    c.share_in_select = 8'h12;
    p.share_data_out = 1'h1;
    p.share_data_disable = 1'h0;
    p.share_clock_disable = 1'h0;
    p.share_clock_out = 1'h1;
    lvl = 32'h10;
    drv = 32'h10;
    apply();
    check("share oe", pad_oe, 32'h8);
    check("share in", shared_in, 4'h6);
    c.share_in_select = 8'h21;
    apply();
    check("share in swap", shared_in, 4'h9);
  endtask : t_shared

  task automatic t_events();
    fresh();
    c.input_gate = 32'h201;
    c.polarity = 32'h200;
    c.irq_pin_mask = 32'h200;
    c.timer0_pin_mask = 32'h1;
    c.timer2_pin_mask = 32'h201;
    lvl = 32'h1;
    drv = 32'h201;
    apply();
    check("irq status", events.irq_status, 32'h200);
    check("irq req", events.gpio_irq_req, 1'h1);
    check("irq cpu", events.gpio_irq_cpu, 1'h0);
    check("t0 status", events.timer0_status, 32'h1);
    check("t1 status", events.timer1_status, 32'h0);
    check("t2 status", events.timer2_status, 32'h201);
    check("timer sig", events.timer_signal, 3'h5);
    check("cpu lines", events.pin_to_cpu_interrupt, 2'h1);
    c.irq_block_enable = 1'h1;
    c.polarity = 32'h1;
    apply();
    check("irq flipped", events.gpio_irq_req, 1'h0);
    check("t0 flipped", events.timer0_status, 32'h0);
    lvl = 32'h0;
    c.timer1_pin_mask = 32'h1;
    c.irq_pin_mask = 32'h1;
    apply();
    check("irq cpu on", events.gpio_irq_cpu, 1'h1);
    check("cpu both", events.pin_to_cpu_interrupt, 2'h3);
  endtask : t_events

  initial begin
    fresh();
    cfg = c;
    periph = p;
    ext_level = lvl;
    ext_drive = drv;
    repeat (5) @(posedge clk);
    #1;
    check("reset oe", pad_oe, 32'h0);
    check("reset strength", pad_drive_strong, 32'hffffffff);
    check("reset irq", events.irq_status, 32'h0);
    @(posedge clk);
    reset <= 1'h0;
    t_general_out();
    t_general_in();
    t_functions();
    t_shared();
    t_events();
    print_verdict();
  end

  initial begin
    repeat (3000) @(posedge clk);
    bad_count++;
    print_verdict();
  end
endmodule : test_pad_mux_and_pin_event_logic
`default_nettype wire
